// *** wdt_consts.svh ***
// offsets, field positions, reset values and counts of the watchdog pair
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
// device register selects on the link
`define WDT_SEL_CLK 2'h0
`define WDT_SEL_CTL 2'h1
`define WDT_SEL_CMP 2'h2
`define WDT_SEL_PROT 2'h3
// protection key, run key values and compare reset value
`define WDT_PROT_KEY 16'h0096
`define WDT_RUN_STOP 4'ha
`define WDT_RUN_READ 4'h0
`define WDT_CMP_RST 10'h3ff
// clock select fields
`define WDT_DBG_BIT 8
`define WDT_DIV_LSB 4
`define WDT_SRC_LSB 0
// control fields
`define WDT_MODE_LSB 9
`define WDT_NMI_BIT 8
`define WDT_CLR_BIT 4
`define WDT_RUN_LSB 0
// divide ratios in source ticks and the source select codes
`define WDT_DIV_BASE 8192
`define WDT_DIV_LOW 128
`define WDT_SRC_LOW 2'h1
`define WDT_SRC_EXT 2'h3
// controller register byte offsets and bit positions
`define WDT_H_CMD 4'h0
`define WDT_H_WDATA 4'h4
`define WDT_H_RDATA 4'h8
`define WDT_H_STAT 4'hc
`define WDT_H_CMD_WR_BIT 8
`define WDT_H_BUSY_BIT 0
`define WDT_H_NMI_BIT 1
`define WDT_H_RST_BIT 2
`endif

// *** wdt_pkg.sv ***
// types shared by the watchdog ends
`default_nettype none
package wdt_pkg;
	typedef enum logic [1:0] {
		WDT_MODE_RESET = 2'b00,
		WDT_MODE_NMI = 2'b01,
		WDT_MODE_NMI_RESET = 2'b10,
		WDT_MODE_RSVD = 2'b11
	} wdt_mode_t;
	typedef enum logic [1:0] {
		WDT_HST_IDLE = 2'b00,
		WDT_HST_WAIT = 2'b01,
		WDT_HST_CAPT = 2'b10
	} wdt_hst_t;
endpackage
`default_nettype wire

// *** wdt_if.sv ***
// link between the watchdog device and its controlling core
`default_nettype none
interface wdt_if;
	logic acc_wr;
	logic acc_rd;
	logic [1:0] acc_sel;
	logic [15:0] acc_wdata;
	logic [15:0] acc_rdata;
	logic dbg_mode;
	logic nmi_req;
	logic rst_req;
	modport dev (
		input acc_wr, acc_rd, acc_sel, acc_wdata, dbg_mode,
		output acc_rdata, nmi_req, rst_req
	);
	modport ctl (
		output acc_wr, acc_rd, acc_sel, acc_wdata, dbg_mode,
		input acc_rdata, nmi_req, rst_req
	);
endinterface
`default_nettype wire

// *** wdt_clkdiv.sv ***
// counter clock prescaler: picks a source tick and divides it
`include "wdt_consts.svh"
`default_nettype none
module wdt_clkdiv import wdt_pkg::*; #(
	parameter int DIV_BASE = `WDT_DIV_BASE,
	parameter int DIV_W = 16
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [3:0] src_tick,
	input wire logic [1:0] src_sel,
	input wire logic [1:0] div_sel,
	input wire logic supply_en,
	output logic cnt_tick
);
	initial begin
		if (DIV_BASE < 1 || DIV_BASE * 8 > (1 << DIV_W))
			$error("wdt_clkdiv: DIV_BASE does not fit DIV_W");
	end

	// ratio minus one for a source and divide choice
	function automatic logic [DIV_W-1:0] ratio_m1(input logic [1:0] src, input logic [1:0] dv);
		logic [DIV_W:0] r;
		r = (DIV_W+1)'(DIV_BASE) << dv;
		if (src == `WDT_SRC_LOW)
			r = (DIV_W+1)'(`WDT_DIV_LOW);
		else if (src == `WDT_SRC_EXT)
			r = (DIV_W+1)'(1);
		ratio_m1 = DIV_W'(r - (DIV_W+1)'(1));
	endfunction

	logic [DIV_W-1:0] cnt;
	wire logic edge_in = supply_en && src_tick[src_sel];
	wire logic wrap = cnt >= ratio_m1(src_sel, div_sel);

	// divider count and output enable pulse
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt <= '0;
			cnt_tick <= 1'b0;
		end else begin
			cnt_tick <= edge_in && wrap;
			if (edge_in)
				cnt <= wrap ? '0 : cnt + DIV_W'(1);
		end
	end
endmodule
`default_nettype wire

// *** wdt_device.sv ***
// watchdog device end: registers, counter, compare and nmi/reset issue
// Operation
// - debug without debug_run freezes the counter clock
// - debug_run keeps the counter clock during debug
// - protected fields writable only after key 0x0096
// - software start order: unlock, configure, clear, run
// - match after compare value plus one ticks
// - counter_clear zeroes counter and nmi flag
// - software clears the counter every timeout period
// - after clear counting restarts from zero
// - compare match issues nmi or reset; in reserved mode 3 the code issues neither
// - nmi sets flag until counter_clear
// - match returns counter to zero, keeps counting
// - mode: reset, nmi, nmi then reset
// - run_key resets to 0xa; 0xa stops
// - non-stop run_key reads back as zero
// - software stop: unlock, write 0xa, relock
// - counting continues while the core halts
// - sleep counts only while source ticks
// - software clears counter before entering sleep
// - clock_source_sel picks implemented source only
// - divide by 8192 to 65536, 128, 1
// - software aims for about 256 Hz
// - nmi handler reads and clears nmi flag
// - compare value resets to 0x3ff
`include "wdt_consts.svh"
`default_nettype none
module wdt_device import wdt_pkg::*; #(
	parameter logic [3:0] SRC_IMPL = 4'hf,
	parameter int DIV_BASE = `WDT_DIV_BASE,
	parameter int DIV_W = 16
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	wdt_if.dev link,
	input wire logic [3:0] src_tick
);
	initial begin
		if (SRC_IMPL[0] == 1'b0)
			$error("wdt_device: the reset source must be implemented");
	end

	logic prot_open;
	logic debug_run;
	logic [1:0] src_sel;
	logic [1:0] div_sel;
	wdt_mode_t mode;
	logic nmi_flag;
	logic [3:0] run_key;
	logic [9:0] cmp;
	logic [9:0] count;
	logic [15:0] rdata;
	logic nmi_q;
	logic rst_q;
	logic cnt_tick;

	// register write decode
	wire logic wr_prot = link.acc_wr && link.acc_sel == `WDT_SEL_PROT;
	wire logic wr_ok = link.acc_wr && prot_open;
	wire logic wr_clk = wr_ok && link.acc_sel == `WDT_SEL_CLK;
	wire logic wr_ctl = wr_ok && link.acc_sel == `WDT_SEL_CTL;
	wire logic wr_cmp = wr_ok && link.acc_sel == `WDT_SEL_CMP;
	wire logic [1:0] new_src = link.acc_wdata[`WDT_SRC_LSB +: 2];
	wire logic [1:0] new_div = link.acc_wdata[`WDT_DIV_LSB +: 2];
	wire logic [3:0] new_run = link.acc_wdata[`WDT_RUN_LSB +: 4];
	wire logic src_ok = SRC_IMPL[new_src];
	wire logic clear_hit = wr_ctl && link.acc_wdata[`WDT_CLR_BIT];

	// run state and clock gating
	wire logic running = run_key == `WDT_RUN_READ;
	wire logic supply_en = !(link.dbg_mode && !debug_run);
	wire logic step = running && cnt_tick;
	wire logic match = step && count == cmp;

	// outcome of a compare match per mode
	wire logic nmi_then_rst = mode == WDT_MODE_NMI_RESET && nmi_flag;
	wire logic fire_rst = match && (mode == WDT_MODE_RESET || nmi_then_rst);
	wire logic fire_nmi = match && (mode == WDT_MODE_NMI ||
		(mode == WDT_MODE_NMI_RESET && !nmi_flag));

	// read mux, reserved bits zero
	wire logic [15:0] rd_clk = {7'h00, debug_run, 2'h0, div_sel, 2'h0, src_sel};
	wire logic [15:0] rd_ctl = {5'h00, mode, nmi_flag, 3'h0, 1'b0, run_key};
	wire logic [15:0] rd_cmp = {6'h00, cmp};
	wire logic [15:0] rd_prot = {15'h0000, prot_open};
	wire logic [15:0] rd_mux = link.acc_sel == `WDT_SEL_CLK ? rd_clk :
		link.acc_sel == `WDT_SEL_CTL ? rd_ctl :
		link.acc_sel == `WDT_SEL_CMP ? rd_cmp : rd_prot;

	assign link.acc_rdata = rdata;
	assign link.nmi_req = nmi_q;
	assign link.rst_req = rst_q;

	wdt_clkdiv #(
		.DIV_BASE(DIV_BASE),
		.DIV_W(DIV_W)
	) u_div (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.src_tick(src_tick),
		.src_sel(src_sel),
		.div_sel(div_sel),
		.supply_en(supply_en),
		.cnt_tick(cnt_tick)
	);

	// protection latch: key opens, any other value closes
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			prot_open <= 1'b0;
		else if (wr_prot)
			prot_open <= link.acc_wdata == `WDT_PROT_KEY;
	end

	// clock select register
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			debug_run <= 1'b0;
			div_sel <= 2'h0;
			src_sel <= 2'h0;
		end else if (wr_clk) begin
			debug_run <= link.acc_wdata[`WDT_DBG_BIT];
			div_sel <= new_div;
			if (src_ok)
				src_sel <= new_src;
		end
	end

	// control and compare registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mode <= WDT_MODE_RESET;
			run_key <= `WDT_RUN_STOP;
			cmp <= `WDT_CMP_RST;
		end else begin
			if (wr_ctl) begin
				mode <= wdt_mode_t'(link.acc_wdata[`WDT_MODE_LSB +: 2]);
				run_key <= new_run == `WDT_RUN_STOP ? `WDT_RUN_STOP : `WDT_RUN_READ;
			end
			if (wr_cmp)
				cmp <= link.acc_wdata[9:0];
		end
	end

	// counter: clear, wrap on match, else step
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			count <= 10'h000;
		else if (clear_hit || match)
			count <= 10'h000;
		else if (step)
			count <= count + 10'h001;
	end

	// nmi flag, a new nmi wins over a clear
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			nmi_flag <= 1'b0;
		else if (fire_nmi)
			nmi_flag <= 1'b1;
		else if (clear_hit)
			nmi_flag <= 1'b0;
	end

	// request pulses and read data
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			nmi_q <= 1'b0;
			rst_q <= 1'b0;
			rdata <= 16'h0000;
		end else begin
			nmi_q <= fire_nmi;
			rst_q <= fire_rst;
			if (link.acc_rd)
				rdata <= rd_mux;
		end
	end
endmodule
`default_nettype wire

// *** wdt_host.sv ***
// controlling core end: ahb-lite registers drive the watchdog link
`include "wdt_consts.svh"
`default_nettype none
module wdt_host import wdt_pkg::*; (
	input wire logic clk_sys,
	input wire logic sys_rst,
	wdt_if.ctl link,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic debug_mode,
	input wire logic cpu_halt,
	output logic cpu_nmi,
	output logic cpu_reset,
	output logic halt_wake
);
	wdt_hst_t state;
	logic pend;
	logic pend_wr;
	logic [3:0] pend_addr;
	logic acc_wr;
	logic acc_rd;
	logic [1:0] acc_sel;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic nmi_seen;
	logic rst_seen;
	logic dbg_q;

	// bus decode
	wire logic take = hsel && htrans[1] && hready;
	wire logic do_wr = pend && pend_wr;
	wire logic busy = state != WDT_HST_IDLE;
	wire logic cmd_go = do_wr && pend_addr == `WDT_H_CMD && !busy;
	wire logic stat_wr = do_wr && pend_addr == `WDT_H_STAT;
	wire logic [31:0] stat = {29'h0, rst_seen, nmi_seen, busy};
	wire logic [31:0] rd_mux = pend_addr == `WDT_H_WDATA ? {16'h0000, wdata} :
		pend_addr == `WDT_H_RDATA ? {16'h0000, rdata} :
		pend_addr == `WDT_H_STAT ? stat : 32'h0000_0000;

	assign link.acc_wr = acc_wr;
	assign link.acc_rd = acc_rd;
	assign link.acc_sel = acc_sel;
	assign link.acc_wdata = wdata;
	assign link.dbg_mode = dbg_q;

	// ahb-lite slave with one wait state
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pend <= 1'b0;
			pend_wr <= 1'b0;
			pend_addr <= 4'h0;
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
		end else if (pend) begin
			pend <= 1'b0;
			hreadyout <= 1'b1;
			if (!pend_wr)
				hrdata <= rd_mux;
		end else if (take) begin
			pend <= 1'b1;
			pend_wr <= hwrite;
			pend_addr <= {haddr[3:2], 2'b00};
			hreadyout <= 1'b0;
		end
	end

	// link access sequencer
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state <= WDT_HST_IDLE;
			acc_wr <= 1'b0;
			acc_rd <= 1'b0;
			acc_sel <= 2'h0;
			wdata <= 16'h0000;
			rdata <= 16'h0000;
		end else begin
			if (do_wr && pend_addr == `WDT_H_WDATA && !busy)
				wdata <= hwdata[15:0];
			unique case (state)
				WDT_HST_IDLE: begin
					if (cmd_go) begin
						acc_sel <= hwdata[1:0];
						acc_wr <= hwdata[`WDT_H_CMD_WR_BIT];
						acc_rd <= !hwdata[`WDT_H_CMD_WR_BIT];
						state <= WDT_HST_WAIT;
					end
				end
				WDT_HST_WAIT: begin
					acc_wr <= 1'b0;
					acc_rd <= 1'b0;
					state <= WDT_HST_CAPT;
				end
				WDT_HST_CAPT: begin
					rdata <= link.acc_rdata;
					state <= WDT_HST_IDLE;
				end
				default: state <= WDT_HST_IDLE;
			endcase
		end
	end

	// core side: requests, sticky status, halt wake
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			dbg_q <= 1'b0;
			cpu_nmi <= 1'b0;
			cpu_reset <= 1'b0;
			halt_wake <= 1'b0;
			nmi_seen <= 1'b0;
			rst_seen <= 1'b0;
		end else begin
			dbg_q <= debug_mode;
			cpu_nmi <= link.nmi_req;
			cpu_reset <= link.rst_req;
			halt_wake <= cpu_halt && (link.nmi_req || link.rst_req);
			if (link.nmi_req)
				nmi_seen <= 1'b1;
			else if (stat_wr && hwdata[`WDT_H_NMI_BIT])
				nmi_seen <= 1'b0;
			if (link.rst_req)
				rst_seen <= 1'b1;
			else if (stat_wr && hwdata[`WDT_H_RST_BIT])
				rst_seen <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** wdt_link_monitor.sv ***
// link checker for the watchdog device end
`default_nettype none
module wdt_link_monitor (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic acc_wr,
	input wire logic acc_rd,
	input wire logic [1:0] acc_sel,
	input wire logic [15:0] acc_wdata,
	input wire logic [15:0] acc_rdata,
	input wire logic dbg_mode,
	input wire logic nmi_req,
	input wire logic rst_req
);
	logic open, stopped, flag;
	logic [1:0] mode, quiet;
	logic [9:0] cmp;
	logic [8:0] cks;
	wire wo = acc_wr && open;
	wire wctl = wo && acc_sel == 2'h1;
	wire hold = stopped || (dbg_mode && !cks[8]);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// shadow of device registers as written over the link
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			open <= 1'b0;
			stopped <= 1'b1;
			flag <= 1'b0;
			mode <= 2'h0;
			cmp <= 10'h3ff;
			cks <= 9'h0;
			quiet <= 2'h0;
		end else begin
			if (acc_wr && acc_sel == 2'h3) open <= acc_wdata == 16'h0096;
			if (wctl) stopped <= acc_wdata[3:0] == 4'ha;
			if (wctl) mode <= acc_wdata[10:9];
			if (wo && acc_sel == 2'h2) cmp <= acc_wdata[9:0];
			if (wo && acc_sel == 2'h0) cks <= acc_wdata[8:0] & 9'h133;
			if (nmi_req) flag <= 1'b1;
			else if (wctl && acc_wdata[4]) flag <= 1'b0;
			quiet <= !hold ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
		end
	end
	prot_read_a: assert property (
		acc_rd && acc_sel == 2'h3 |=> acc_rdata == {15'h0, open})
		else $error("protect readback wrong");
	clk_read_a: assert property (
		acc_rd && acc_sel == 2'h0 |=> acc_rdata == {7'h0, cks})
		else $error("clock select readback wrong");
	cmp_read_a: assert property (
		acc_rd && acc_sel == 2'h2 |=> acc_rdata == {6'h0, cmp})
		else $error("compare readback wrong");
	ctl_read_a: assert property (
		acc_rd && acc_sel == 2'h1 |=> acc_rdata[4:0] == {1'b0, stopped ? 4'ha : 4'h0}
		&& acc_rdata[10:9] == mode)
		else $error("control readback wrong");
	req_excl_a: assert property (!(nmi_req && rst_req))
		else $error("nmi and reset together");
	frozen_quiet_a: assert property (quiet == 2'h3 |-> !nmi_req && !rst_req)
		else $error("request while stopped or frozen");
	nmi_mode_a: assert property (
		nmi_req |-> mode == 2'h1 || (mode == 2'h2 && !flag))
		else $error("nmi in wrong mode");
	rst_mode_a: assert property (
		rst_req |-> mode == 2'h0 || (mode == 2'h2 && flag))
		else $error("reset in wrong mode");
endmodule
`default_nettype wire

// *** watchdog_nmi_reset_timer_tb.sv ***
// testbench: host and device joined by the link, driven over ahb-lite
`default_nettype none
module watchdog_nmi_reset_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, sys_rst, hsel, hwrite, debug_mode, cpu_halt;
	logic hreadyout, hresp, cpu_nmi, cpu_reset, halt_wake;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] src_tick;
	int fail_count, cmp_count, nmi_cnt, rst_cnt, wake_cnt;
	localparam int EN[4] = '{0, 2, 1, 0};
	localparam int ER[4] = '{2, 0, 1, 0};
	localparam int CK[5] = '{'h00, 'h10, 'h20, 'h32, 'h01};
	localparam int SB[5] = '{0, 0, 0, 2, 1};
	localparam int RT[5] = '{2, 4, 8, 16, 128};
	wdt_if wdt_if_inst ();
	wdt_device #(.DIV_BASE(2)) wdt_device_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.link(wdt_if_inst), .src_tick(src_tick));
	wdt_host wdt_host_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(wdt_if_inst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .debug_mode(debug_mode), .cpu_halt(cpu_halt), .cpu_nmi(cpu_nmi),
		.cpu_reset(cpu_reset), .halt_wake(halt_wake));
	wdt_link_monitor wdt_link_monitor_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.acc_wr(wdt_if_inst.acc_wr), .acc_rd(wdt_if_inst.acc_rd),
		.acc_sel(wdt_if_inst.acc_sel), .acc_wdata(wdt_if_inst.acc_wdata),
		.acc_rdata(wdt_if_inst.acc_rdata), .dbg_mode(wdt_if_inst.dbg_mode),
		.nmi_req(wdt_if_inst.nmi_req), .rst_req(wdt_if_inst.rst_req));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// count core-side pulses
	always @(posedge clk_sys) begin
		nmi_cnt += int'(cpu_nmi === 1'b1);
		rst_cnt += int'(cpu_reset === 1'b1);
		wake_cnt += int'(halt_wake === 1'b1);
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	// one single ahb transfer, read data left in rd
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task idle;
		do xfer(1'b0, 32'hc, 32'h0); while (rd[0] !== 1'b0);
	endtask
	task dwr(input logic [1:0] s, input logic [15:0] d);
		xfer(1'b1, 32'h4, {16'h0, d});
		xfer(1'b1, 32'h0, {30'h40, s});
		idle();
	endtask
	task drd(input logic [1:0] s);
		xfer(1'b1, 32'h0, {30'h0, s});
		idle();
		xfer(1'b0, 32'h8, 32'h0);
	endtask
	task tick(input int b, input int n);
		repeat (n) begin
			@(posedge clk_sys);
			src_tick[b] <= 1'b1;
			@(posedge clk_sys);
			src_tick <= 4'h0;
		end
		repeat (6) @(posedge clk_sys);
	endtask
	task want(input int n, input int r);
		chk(nmi_cnt, n);
		chk(rst_cnt, r);
	endtask
	task t_regs;
		drd(2'h1); chk(rd, 32'ha);
		drd(2'h2); chk(rd, 32'h3ff);
		drd(2'h0); chk(rd, 32'h0);
		xfer(1'b0, 32'h10, 32'h0); chk(rd, 32'h0);
		dwr(2'h2, 16'h5); drd(2'h2); chk(rd, 32'h3ff);
		chk({31'h0, hresp}, 32'h0);
		dwr(2'h3, 16'h0096); drd(2'h3); chk(rd, 32'h1);
		dwr(2'h2, 16'h5); drd(2'h2); chk(rd, 32'h5);
		dwr(2'h3, 16'h0); drd(2'h3); chk(rd, 32'h0);
		dwr(2'h3, 16'h0096);
	endtask
	task t_timeout;
		dwr(2'h0, 16'h3); dwr(2'h2, 16'h3); dwr(2'h1, 16'h0210);
		nmi_cnt = 0; rst_cnt = 0;
		tick(3, 3); want(0, 0);
		tick(3, 1); want(1, 0);
		drd(2'h1); chk(rd, 32'h300);
		xfer(1'b0, 32'hc, 32'h0); chk(rd & 32'h7, 32'h2);
		tick(3, 4); want(2, 0);
		tick(3, 2); dwr(2'h1, 16'h0210);
		drd(2'h1); chk(rd, 32'h200);
		tick(3, 3); want(2, 0);
		tick(3, 1); want(3, 0);
	endtask
	task t_modes;
		for (int m = 0; m < 4; m++) begin
			dwr(2'h1, 16'(m << 9) | 16'h10);
			nmi_cnt = 0; rst_cnt = 0;
			tick(3, 8); want(EN[m], ER[m]);
		end
	endtask
	task t_debug;
		dwr(2'h1, 16'h0210); nmi_cnt = 0;
		tick(3, 2); @(posedge clk_sys) debug_mode <= 1'b1;
		tick(3, 8); want(0, 0);
		@(posedge clk_sys) debug_mode <= 1'b0;
		tick(3, 2); want(1, 0);
		dwr(2'h0, 16'h103); @(posedge clk_sys) debug_mode <= 1'b1;
		dwr(2'h1, 16'h0210); tick(3, 4); want(2, 0);
		@(posedge clk_sys) debug_mode <= 1'b0;
		cpu_halt <= 1'b1; wake_cnt = 0;
		dwr(2'h1, 16'h0210); tick(3, 4); chk(wake_cnt, 1);
		@(posedge clk_sys) cpu_halt <= 1'b0;
	endtask
	// stopped source holds the count; run key 0xa stops; relocked writes refused
	task t_stop;
		dwr(2'h1, 16'h0210); nmi_cnt = 0; rst_cnt = 0;
		repeat (40) @(posedge clk_sys); want(0, 0);
		tick(3, 2); dwr(2'h1, 16'h021a);
		drd(2'h1); chk(rd, 32'h20a);
		tick(3, 8); want(0, 0);
		dwr(2'h3, 16'h0); dwr(2'h1, 16'h0210);
		drd(2'h1); chk(rd, 32'h20a);
		tick(3, 8); want(0, 0);
		dwr(2'h3, 16'h0096);
	endtask
	task t_div;
		dwr(2'h2, 16'h0);
		for (int i = 0; i < 5; i++) begin
			dwr(2'h0, 16'(CK[i])); dwr(2'h1, 16'h0210); nmi_cnt = 0;
			tick(SB[i], 4 * RT[i]); chk(nmi_cnt, 4);
		end
	endtask
	task finish_test;
		$display("checks %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#300us;
		fail_count++;
		finish_test();
	end
	initial begin
		sys_rst = 1'b1;
		{hsel, hwrite, debug_mode, cpu_halt} = 4'h0;
		{haddr, hwdata, htrans, src_tick} = '0;
		hsize = 3'b010;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_regs(); t_timeout(); t_modes(); t_debug(); t_stop(); t_div();
		finish_test();
	end
endmodule
`default_nettype wire
